// ---- design/dtc_threshold_ctrl.sv ----
// Dynamic threshold control registers one and two with operating points, capture and interval pacing.
`timescale 1ns/1ps
`include "dtc_consts.svh"

module dtc_threshold_ctrl
	import dtc_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic sys_rst,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Thermal alert pin and measurements.
	input wire logic thermal_alert_pin_n,
	input wire logic monitor_tick,
	input wire dtc_meas_t meas,
	// Outputs to the fan control loop.
	output dtc_op_t op_point,
	output dtc_adjust_t adjust,
	output logic cfg_locked
);

	function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
		addr_is = (addr == target);
	endfunction : addr_is

	dtc_byte_t ctrl_one;
	dtc_byte_t ctrl_two;
	dtc_byte_t next_ctrl_one;
	dtc_byte_t next_ctrl_two;
	dtc_byte_t read_mux;
	dtc_op_t latest_temp;
	dtc_op_t next_op_point;
	dtc_code_t code [3];
	logic alert_prev_n;
	logic alert_edge;
	logic wr_ctrl_one;
	logic wr_ctrl_two;
	logic wr_lock;
	logic [2:0] wr_op;
	logic [2:0] capture;
	logic [2:0] dec_strobe;
	logic [2:0] inc_strobe;

	assign wr_ctrl_one = reg_wr && !cfg_locked && addr_is(reg_addr, `DTC_ADDR_CTRL_ONE);
	assign wr_ctrl_two = reg_wr && !cfg_locked && addr_is(reg_addr, `DTC_ADDR_CTRL_TWO);
	assign wr_lock = reg_wr && addr_is(reg_addr, `DTC_ADDR_LOCK) && reg_wdata[`DTC_BIT_LOCK];
	assign wr_op[0] = reg_wr && !cfg_locked && addr_is(reg_addr, `DTC_ADDR_OP_REMOTE_ONE);
	assign wr_op[1] = reg_wr && !cfg_locked && addr_is(reg_addr, `DTC_ADDR_OP_LOCAL);
	assign wr_op[2] = reg_wr && !cfg_locked && addr_is(reg_addr, `DTC_ADDR_OP_REMOTE_TWO);

	assign next_ctrl_one = wr_ctrl_one ? (reg_wdata & `DTC_CTRL_ONE_RW_MASK) : ctrl_one;
	assign next_ctrl_two = wr_ctrl_two ? reg_wdata : ctrl_two;

	assign alert_edge = alert_prev_n && !thermal_alert_pin_n;

	assign code[0] = ctrl_two[`DTC_LSB_R1_CODE +: 3];
	assign code[1] = ctrl_two[`DTC_LSB_LOCAL_CODE +: 3];
	assign code[2] = {ctrl_one[`DTC_BIT_R2_CODE_MSB], ctrl_two[`DTC_LSB_R2_CODE +: 2]};

	assign read_mux =
		addr_is(reg_addr, `DTC_ADDR_CTRL_ONE) ? ctrl_one :
		addr_is(reg_addr, `DTC_ADDR_CTRL_TWO) ? ctrl_two :
		addr_is(reg_addr, `DTC_ADDR_OP_REMOTE_ONE) ? op_point[0] :
		addr_is(reg_addr, `DTC_ADDR_OP_LOCAL) ? op_point[1] :
		addr_is(reg_addr, `DTC_ADDR_OP_REMOTE_TWO) ? op_point[2] :
		addr_is(reg_addr, `DTC_ADDR_LOCK) ? {7'h00, cfg_locked} : 8'h00;

	genvar ch;
	generate
		for (ch = 0; ch < 3; ch++) begin : g_chan
			assign capture[ch] = alert_edge && ctrl_one[`DTC_BIT_CAPTURE_BASE + ch];
			assign next_op_point[ch] = capture[ch] ? latest_temp[ch] :
				wr_op[ch] ? reg_wdata : op_point[ch];

			always_ff @(posedge mclk) begin
				if (sys_rst) begin
					latest_temp[ch] <= `DTC_RST_TEMP;
					op_point[ch] <= `DTC_RST_OP_POINT;
				end else begin
					if (meas.valid[ch]) begin
						latest_temp[ch] <= meas.temp[ch];
					end
					op_point[ch] <= next_op_point[ch];
				end
			end

			dtc_interval_timer u_timer (
				.mclk(mclk),
				.sys_rst(sys_rst),
				.enable(ctrl_one[`DTC_BIT_DYN_BASE + ch]),
				.monitor_tick(monitor_tick),
				.code(code[ch]),
				.dec_strobe(dec_strobe[ch]),
				.inc_strobe(inc_strobe[ch])
			);

			a_capture_copies: assert property (@(posedge mclk) disable iff (sys_rst)
				capture[ch] |=> op_point[ch] == $past(latest_temp[ch]))
				else $error("Operating point missed the captured temperature");

			a_capture_blocked: assert property (@(posedge mclk) disable iff (sys_rst)
				alert_edge && !ctrl_one[`DTC_BIT_CAPTURE_BASE + ch] && !wr_op[ch]
				|=> $stable(op_point[ch]))
				else $error("Operating point changed with capture disabled");

			a_latest_tracks: assert property (@(posedge mclk) disable iff (sys_rst)
				meas.valid[ch] |=> latest_temp[ch] == $past(meas.temp[ch]))
				else $error("Completed measurement not stored");

			a_op_write_lands: assert property (@(posedge mclk) disable iff (sys_rst)
				wr_op[ch] && !capture[ch] |=> op_point[ch] == $past(reg_wdata))
				else $error("Operating point write lost");
		end
	endgenerate

	assign adjust.dyn_en = ctrl_one[`DTC_BIT_DYN_BASE +: 3];
	assign adjust.dec_strobe = dec_strobe;
	assign adjust.inc_strobe = inc_strobe;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ctrl_one <= `DTC_RST_CTRL_ONE;
			ctrl_two <= `DTC_RST_CTRL_TWO;
			alert_prev_n <= 1'b1;
			cfg_locked <= 1'b0;
			reg_rdata <= 8'h00;
		end else begin
			ctrl_one <= next_ctrl_one;
			ctrl_two <= next_ctrl_two;
			alert_prev_n <= thermal_alert_pin_n;
			cfg_locked <= cfg_locked || wr_lock;
			reg_rdata <= reg_rd ? read_mux : 8'h00;
		end
	end

	a_lock_holds: assert property (@(posedge mclk) disable iff (sys_rst)
		cfg_locked && reg_wr |=> $stable(ctrl_one) && $stable(ctrl_two))
		else $error("Locked control register was written");

	a_lock_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
		cfg_locked |=> cfg_locked [*3])
		else $error("Lock bit cleared without reset");

	a_rsvd_zero: assert property (@(posedge mclk) disable iff (sys_rst)
		reg_rd && addr_is(reg_addr, `DTC_ADDR_CTRL_ONE) |=> reg_rdata[`DTC_BIT_RSVD] == 1'b0)
		else $error("Reserved bit read as one");

	a_code_msb_write: assert property (@(posedge mclk) disable iff (sys_rst)
		wr_ctrl_one |=> code[2][2] == $past(reg_wdata[`DTC_BIT_R2_CODE_MSB]))
		else $error("Remote two code MSB not taken from write");

	a_once_per_event: assert property (@(posedge mclk) disable iff (sys_rst)
		!thermal_alert_pin_n && !alert_prev_n |-> capture == 3'b000)
		else $error("Capture repeated during one assertion");

	a_dyn_off_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
		!adjust.dyn_en[2] ##1 !adjust.dyn_en[2] |-> !adjust.dec_strobe[2] && !adjust.inc_strobe[2])
		else $error("Remote two adjusts while disabled");

	a_read_op_point: assert property (@(posedge mclk) disable iff (sys_rst)
		reg_rd && addr_is(reg_addr, `DTC_ADDR_OP_LOCAL) |=> reg_rdata == $past(op_point[1]))
		else $error("Local operating point read mismatch");

	a_rdata_one_cycle: assert property (@(posedge mclk) disable iff (sys_rst)
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("Read data outside its cycle");

	a_ctrl_one_write: assert property (@(posedge mclk) disable iff (sys_rst)
		wr_ctrl_one |=> ctrl_one == ($past(reg_wdata) & `DTC_CTRL_ONE_RW_MASK))
		else $error("Control register one write lost");

	a_ctrl_one_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		!wr_ctrl_one |=> $stable(ctrl_one))
		else $error("Control register one changed without a write");

	a_ctrl_two_write: assert property (@(posedge mclk) disable iff (sys_rst)
		wr_ctrl_two |=> ctrl_two == $past(reg_wdata))
		else $error("Control register two write lost");

	a_ctrl_two_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		!wr_ctrl_two |=> $stable(ctrl_two))
		else $error("Control register two changed without a write");

	a_rsvd_never_set: assert property (@(posedge mclk) disable iff (sys_rst)
		ctrl_one[`DTC_BIT_RSVD] == 1'b0)
		else $error("Reserved bit stored as one");

	a_code_lsb_write: assert property (@(posedge mclk) disable iff (sys_rst)
		wr_ctrl_two |=> code[2][1:0] == $past(reg_wdata[`DTC_LSB_R2_CODE +: 2]))
		else $error("Remote two code low bits not taken from write");

	a_r1_capture: assert property (@(posedge mclk) disable iff (sys_rst)
		$fell(thermal_alert_pin_n) && ctrl_one[`DTC_BIT_CAPTURE_BASE]
		|=> op_point[0] == $past(latest_temp[0]))
		else $error("Remote one temperature not captured");

	a_local_capture: assert property (@(posedge mclk) disable iff (sys_rst)
		$fell(thermal_alert_pin_n) && ctrl_one[`DTC_BIT_CAPTURE_BASE + 1]
		|=> op_point[1] == $past(latest_temp[1]))
		else $error("Local temperature not captured");

	a_r2_capture: assert property (@(posedge mclk) disable iff (sys_rst)
		$fell(thermal_alert_pin_n) && ctrl_one[`DTC_BIT_CAPTURE_BASE + 2]
		|=> op_point[2] == $past(latest_temp[2]))
		else $error("Remote two temperature not captured");

	a_r1_keep: assert property (@(posedge mclk) disable iff (sys_rst)
		!ctrl_one[`DTC_BIT_CAPTURE_BASE] && !wr_op[0] |=> $stable(op_point[0]))
		else $error("Remote one operating point moved while capture disabled");

	a_local_keep: assert property (@(posedge mclk) disable iff (sys_rst)
		!ctrl_one[`DTC_BIT_CAPTURE_BASE + 1] && !wr_op[1] |=> $stable(op_point[1]))
		else $error("Local operating point moved while capture disabled");

	a_r2_keep: assert property (@(posedge mclk) disable iff (sys_rst)
		!ctrl_one[`DTC_BIT_CAPTURE_BASE + 2] && !wr_op[2] |=> $stable(op_point[2]))
		else $error("Remote two operating point moved while capture disabled");

	a_once_held: assert property (@(posedge mclk) disable iff (sys_rst)
		!alert_prev_n && !thermal_alert_pin_n && wr_op == 3'b000 |=> $stable(op_point))
		else $error("Operating point moved while the pin stayed asserted");

	a_lock_set: assert property (@(posedge mclk) disable iff (sys_rst)
		wr_lock |=> cfg_locked)
		else $error("Lock write did not set the lock");

	a_lock_stops_op: assert property (@(posedge mclk) disable iff (sys_rst)
		cfg_locked && capture == 3'b000 |=> $stable(op_point))
		else $error("Locked operating point was written");

	a_lock_read: assert property (@(posedge mclk) disable iff (sys_rst)
		reg_rd && addr_is(reg_addr, `DTC_ADDR_LOCK) |=> reg_rdata == {7'h00, $past(cfg_locked)})
		else $error("Lock state read mismatch");

	a_read_ctrl_one: assert property (@(posedge mclk) disable iff (sys_rst)
		reg_rd && addr_is(reg_addr, `DTC_ADDR_CTRL_ONE) |=> reg_rdata == $past(ctrl_one))
		else $error("Control register one read mismatch");

	a_read_ctrl_two: assert property (@(posedge mclk) disable iff (sys_rst)
		reg_rd && addr_is(reg_addr, `DTC_ADDR_CTRL_TWO) |=> reg_rdata == $past(ctrl_two))
		else $error("Control register two read mismatch");

	a_read_op_r1: assert property (@(posedge mclk) disable iff (sys_rst)
		reg_rd && addr_is(reg_addr, `DTC_ADDR_OP_REMOTE_ONE)
		|=> reg_rdata == $past(op_point[0]))
		else $error("Remote one operating point read mismatch");

	a_read_op_r2: assert property (@(posedge mclk) disable iff (sys_rst)
		reg_rd && addr_is(reg_addr, `DTC_ADDR_OP_REMOTE_TWO)
		|=> reg_rdata == $past(op_point[2]))
		else $error("Remote two operating point read mismatch");

	a_dyn_written: assert property (@(posedge mclk) disable iff (sys_rst)
		wr_ctrl_one |=> adjust.dyn_en == $past(reg_wdata[`DTC_BIT_DYN_BASE +: 3]))
		else $error("Dynamic enables not taken from write");

	a_r1_dyn_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
		!adjust.dyn_en[0] ##1 !adjust.dyn_en[0]
		|-> !adjust.dec_strobe[0] && !adjust.inc_strobe[0])
		else $error("Remote one adjusts while disabled");

	a_local_dyn_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
		!adjust.dyn_en[1] ##1 !adjust.dyn_en[1]
		|-> !adjust.dec_strobe[1] && !adjust.inc_strobe[1])
		else $error("Local channel adjusts while disabled");

	a_r2_needs_en: assert property (@(posedge mclk) disable iff (sys_rst)
		adjust.dec_strobe[2] || adjust.inc_strobe[2] |-> $past(adjust.dyn_en[2]))
		else $error("Remote two strobe without its enable");

	a_strobe_on_tick: assert property (@(posedge mclk) disable iff (sys_rst)
		(adjust.dec_strobe | adjust.inc_strobe) != 3'b000 |-> $past(monitor_tick))
		else $error("Adjustment strobe without a monitoring tick");

	a_dec_inc_apart: assert property (@(posedge mclk) disable iff (sys_rst)
		(adjust.dec_strobe & adjust.inc_strobe) == 3'b000)
		else $error("Decrease and increase strobes together");

endmodule : dtc_threshold_ctrl

// ---- inc/dtc_consts.svh ----
// Register offsets, field positions, reset values and interval figures of the threshold block.
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

`define DTC_ADDR_OP_REMOTE_ONE 8'h33
`define DTC_ADDR_OP_LOCAL 8'h34
`define DTC_ADDR_OP_REMOTE_TWO 8'h35
`define DTC_ADDR_CTRL_ONE 8'h36
`define DTC_ADDR_CTRL_TWO 8'h37
`define DTC_ADDR_LOCK 8'h40

`define DTC_RST_OP_POINT 8'h64
`define DTC_RST_CTRL_ONE 8'h00
`define DTC_RST_CTRL_TWO 8'h00
`define DTC_RST_TEMP 8'h80

`define DTC_CTRL_ONE_RW_MASK 8'hFD
`define DTC_BIT_R2_CODE_MSB 0
`define DTC_BIT_RSVD 1
`define DTC_BIT_CAPTURE_BASE 2
`define DTC_BIT_DYN_BASE 5
`define DTC_BIT_LOCK 0

`define DTC_LSB_R1_CODE 0
`define DTC_LSB_LOCAL_CODE 3
`define DTC_LSB_R2_CODE 6

`define DTC_DEC_BASE_CYCLES 11'h004
`define DTC_INC_BASE_CYCLES 11'h008

`endif

// ---- inc/dtc_pkg.sv ----
// Types shared by the threshold control block and its interval timer.
package dtc_pkg;

	typedef logic [7:0] dtc_byte_t;
	typedef logic [2:0] dtc_code_t;
	typedef logic [10:0] dtc_count_t;

	// Channel order everywhere: 0 remote one, 1 local, 2 remote two.
	typedef struct packed {
		logic [2:0] valid;
		logic [2:0][7:0] temp;
	} dtc_meas_t;

	typedef struct packed {
		logic [2:0] dyn_en;
		logic [2:0] dec_strobe;
		logic [2:0] inc_strobe;
	} dtc_adjust_t;

	typedef logic [2:0][7:0] dtc_op_t;

endpackage : dtc_pkg

// ---- design/dtc_interval_timer.sv ----
// Interval timer that paces threshold decrease and increase steps for one channel.
`timescale 1ns/1ps
`include "dtc_consts.svh"

module dtc_interval_timer
	import dtc_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic sys_rst,
	// Pacing control.
	input wire logic enable,
	input wire logic monitor_tick,
	input wire dtc_code_t code,
	// Adjustment strobes.
	output logic dec_strobe,
	output logic inc_strobe
);

	dtc_count_t count;
	dtc_count_t next_count;
	dtc_count_t dec_last;
	dtc_count_t inc_last;
	logic at_dec;
	logic at_inc;

	assign dec_last = dtc_count_t'((`DTC_DEC_BASE_CYCLES << code) - 11'h001);
	assign inc_last = dtc_count_t'((`DTC_INC_BASE_CYCLES << code) - 11'h001);
	assign at_dec = monitor_tick && (count == dec_last);
	assign at_inc = monitor_tick && (count == inc_last);
	assign next_count = !enable ? 11'h000 :
		at_inc ? 11'h000 :
		monitor_tick ? dtc_count_t'(count + 11'h001) : count;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			count <= 11'h000;
			dec_strobe <= 1'b0;
			inc_strobe <= 1'b0;
		end else begin
			count <= next_count;
			dec_strobe <= enable && at_dec;
			inc_strobe <= enable && at_inc;
		end
	end

	a_dec_at_count: assert property (@(posedge mclk) disable iff (sys_rst)
		dec_strobe |-> $past(monitor_tick) && $past(count) == $past(dec_last))
		else $error("Decrease strobe off its interval");

	a_idle_disabled: assert property (@(posedge mclk) disable iff (sys_rst)
		!enable ##1 !enable |-> count == 11'h000 && !dec_strobe && !inc_strobe)
		else $error("Timer runs while disabled");

endmodule : dtc_interval_timer

// ---- bench/testbench.sv ----
// Self-checking bench for the threshold control register block.
`timescale 1ns/1ps
`include "dtc_consts.svh"

module testbench
	import dtc_pkg::*;
;
	logic mclk;
	logic sys_rst;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic thermal_alert_pin_n;
	logic monitor_tick;
	dtc_meas_t meas;
	dtc_op_t op_point;
	dtc_adjust_t adjust;
	logic cfg_locked;
	int fails;
	int num_checks;
	int cycles;
	int dec_at;
	int inc_at;
	logic [7:0] rd_val;

	dtc_threshold_ctrl dut (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.thermal_alert_pin_n(thermal_alert_pin_n),
		.monitor_tick(monitor_tick),
		.meas(meas),
		.op_point(op_point),
		.adjust(adjust),
		.cfg_locked(cfg_locked)
	);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task finish_test();
		if (fails == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test

	task check(input logic [23:0] seen, input logic [23:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	task rd(input logic [7:0] a);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		rd_val = reg_rdata;
	endtask : rd

	task load_meas(input logic [7:0] t0, input logic [7:0] t1, input logic [7:0] t2);
		@(posedge mclk);
		meas.valid <= 3'h7;
		meas.temp <= {t2, t1, t0};
		@(posedge mclk);
		meas.valid <= 3'h0;
	endtask : load_meas

	// Drops the alert pin and returns once the edge has landed in the operating points.
	task alert();
		@(posedge mclk);
		thermal_alert_pin_n <= 1'b0;
		@(posedge mclk);
		#1;
	endtask : alert

	task pace(input int n);
		dec_at = 0;
		inc_at = 0;
		for (int i = 1; i <= n; i++) begin
			@(posedge mclk);
			monitor_tick <= 1'b1;
			@(posedge mclk);
			monitor_tick <= 1'b0;
			#1;
			// An index is negative when the three channels do not strobe together.
			if (adjust.dec_strobe !== 3'h0 && dec_at == 0)
				dec_at = (adjust.dec_strobe === 3'h7) ? i : -i;
			if (adjust.inc_strobe !== 3'h0 && inc_at == 0)
				inc_at = (adjust.inc_strobe === 3'h7) ? i : -i;
		end
	endtask : pace

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			finish_test();
		end
	end

	initial begin
		fails = 0;
		num_checks = 0;
		cycles = 0;
		sys_rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		thermal_alert_pin_n = 1'b1;
		monitor_tick = 1'b0;
		meas = '0;
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(`DTC_ADDR_CTRL_ONE);
		check(rd_val, `DTC_RST_CTRL_ONE, "ctrl one reset");
		rd(`DTC_ADDR_OP_LOCAL);
		check(rd_val, `DTC_RST_OP_POINT, "op point reset");
		wr(`DTC_ADDR_CTRL_ONE, 8'hFF);
		rd(`DTC_ADDR_CTRL_ONE);
		check(rd_val, 8'hFD, "reserved bit");
		check(adjust.dyn_en, 3'h7, "dynamic enables set");
		wr(`DTC_ADDR_CTRL_ONE, 8'h14);
		check(adjust.dyn_en, 3'h0, "dynamic enables clear");
		load_meas(8'h50, 8'h51, 8'h52);
		alert();
		check(op_point, 24'h526450, "capture remote channels");
		load_meas(8'h60, 8'h61, 8'h62);
		repeat (3) @(posedge mclk);
		#1;
		check(op_point, 24'h526450, "held pin no recapture");
		@(posedge mclk);
		thermal_alert_pin_n <= 1'b1;
		wr(`DTC_ADDR_CTRL_ONE, 8'h08);
		alert();
		check(op_point, 24'h526150, "capture local only");
		thermal_alert_pin_n <= 1'b1;
		rd(`DTC_ADDR_OP_REMOTE_ONE);
		check(rd_val, 8'h50, "captured value readback");
		// Every code on all three channels; remote two codes from four up need the top bit in register one.
		for (int c = 0; c < 8; c++) begin
			wr(`DTC_ADDR_CTRL_ONE, 8'h00);
			wr(`DTC_ADDR_CTRL_TWO, 8'(((c % 4) << 6) | (c << 3) | c));
			wr(`DTC_ADDR_CTRL_ONE, 8'hE0 | 8'(c / 4));
			pace(8 << c);
			check(24'(dec_at), 24'(4 << c), "decrease interval");
			check(24'(inc_at), 24'(8 << c), "increase interval");
		end
		rd(`DTC_ADDR_CTRL_TWO);
		check(rd_val, 8'hFF, "control two readback");
		wr(`DTC_ADDR_LOCK, 8'h01);
		check(cfg_locked, 1'b1, "lock set");
		wr(`DTC_ADDR_CTRL_ONE, 8'h3C);
		rd(`DTC_ADDR_CTRL_ONE);
		check(rd_val, 8'hE1, "locked write ignored");
		wr(`DTC_ADDR_CTRL_TWO, 8'h00);
		rd(`DTC_ADDR_CTRL_TWO);
		check(rd_val, 8'hFF, "locked control two");
		rd(`DTC_ADDR_LOCK);
		check(rd_val, 8'h01, "lock readback");
		wr(`DTC_ADDR_OP_LOCAL, 8'h20);
		rd(`DTC_ADDR_OP_LOCAL);
		check(rd_val, 8'h61, "locked op point");
		rd(8'h50);
		check(rd_val, 8'h00, "unmapped read");
		finish_test();
	end
endmodule : testbench
